// ### hw/aohtr_pkg.sv
// Package: register map and constants for the offset hold and test register bank
package aohtr_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] RO_A_ADDR = 8'h2a;
  localparam logic [7:0] RO_B_ADDR = 8'h2b;
  localparam logic [7:0] HOLD_CTL_ADDR = 8'h2c;
  localparam logic [7:0] FIX_A_ADDR = 8'h2d;
  localparam logic [7:0] FIX_B_ADDR = 8'h2e;
  localparam logic [7:0] LAST_ADDR = 8'h2e;
  // ==========================================================================
  // Fields and reset values
  localparam int HOLD_BIT = 4;
  localparam logic [7:0] HOLD_CTL_RST = 8'h00;
  localparam logic [7:0] FIX_A_RST = 8'h00;
  localparam logic [7:0] FIX_B_RST = 8'h00;
  localparam logic [7:0] RO_A_VAL = 8'h00;
  localparam logic [7:0] RO_B_VAL = 8'h00;
  // ==========================================================================
  // Offset loop timing
  localparam int SETTLE_UPDATES = 10;
  localparam logic [3:0] SETTLE_MAX = 4'ha;
endpackage : aohtr_pkg

// ### hw/aohtr_regs.sv
// Offset hold control and test register bank behind the serial port
// Contract
// - With hold clear and the loop enabled, every scheduled update loads a new offset correction.
// - With hold set, updates stop and the last correction stays applied.
// - The loop reports settled within at most ten updates after it starts.
// - Third and fourth test registers are read-only reserved bytes.
// - Fifth and sixth test registers are plain read/write bytes.
// - Addresses above the last test register are not acknowledged.
`timescale 1ns/1ps
`default_nettype none
module aohtr_regs (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Register port from the serial engine
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_ack_o,
  // Offset loop
  input wire logic offset_enable_i,
  input wire logic update_tick_i,
  input wire logic [7:0] offset_calc_i,
  output logic [7:0] offset_applied_o,
  output logic offset_hold_o,
  output logic offset_settled_o,
  // Registered copies of the read/write fix bytes
  output logic [7:0] fixed_a_o,
  output logic [7:0] fixed_b_o
);
  // ==========================================================================
  // Decode
  logic [7:0] hold_ctl_ff;
  logic [7:0] fix_a_ff;
  logic [7:0] fix_b_ff;
  logic [7:0] offset_ff;
  logic [3:0] upd_cnt_ff;
  logic [7:0] nxt_rdata;
  logic [3:0] nxt_upd_cnt;
  logic in_range;
  logic sel_hold;
  logic sel_fix_a;
  logic sel_fix_b;
  logic do_update;
  logic hold_now;

  assign in_range = (reg_addr_i <= aohtr_pkg::LAST_ADDR);
  assign sel_hold = reg_wr_i && (reg_addr_i == aohtr_pkg::HOLD_CTL_ADDR);
  assign sel_fix_a = reg_wr_i && (reg_addr_i == aohtr_pkg::FIX_A_ADDR);
  assign sel_fix_b = reg_wr_i && (reg_addr_i == aohtr_pkg::FIX_B_ADDR);
  assign hold_now = hold_ctl_ff[aohtr_pkg::HOLD_BIT];
  // Held loop ignores ticks so the last result stays put
  assign do_update = offset_enable_i && update_tick_i && !hold_now;
  // Count saturates; restart whenever the loop is disabled or held
  assign nxt_upd_cnt = (!offset_enable_i || hold_now) ? 4'h0 :
                       (do_update && upd_cnt_ff != aohtr_pkg::SETTLE_MAX) ?
                       upd_cnt_ff + 4'h1 : upd_cnt_ff;
  // Read-only bytes return fixed values; writes to them fall through unused
  assign nxt_rdata = (reg_addr_i == aohtr_pkg::RO_A_ADDR) ? aohtr_pkg::RO_A_VAL :
                     (reg_addr_i == aohtr_pkg::RO_B_ADDR) ? aohtr_pkg::RO_B_VAL :
                     (reg_addr_i == aohtr_pkg::HOLD_CTL_ADDR) ? hold_ctl_ff :
                     (reg_addr_i == aohtr_pkg::FIX_A_ADDR) ? fix_a_ff :
                     (reg_addr_i == aohtr_pkg::FIX_B_ADDR) ? fix_b_ff : 8'h00;

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      hold_ctl_ff <= aohtr_pkg::HOLD_CTL_RST;
      fix_a_ff <= aohtr_pkg::FIX_A_RST;
      fix_b_ff <= aohtr_pkg::FIX_B_RST;
    end else begin
      // Full byte stored so software sees what it wrote
      if (sel_hold) hold_ctl_ff <= reg_wdata_i;
      if (sel_fix_a) fix_a_ff <= reg_wdata_i;
      if (sel_fix_b) fix_b_ff <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      offset_ff <= 8'h00;
      upd_cnt_ff <= 4'h0;
    end else begin
      if (do_update) offset_ff <= offset_calc_i;
      upd_cnt_ff <= nxt_upd_cnt;
    end
  end

  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
      reg_ack_o <= 1'b0;
      offset_applied_o <= 8'h00;
      offset_hold_o <= 1'b0;
      offset_settled_o <= 1'b0;
      fixed_a_o <= aohtr_pkg::FIX_A_RST;
      fixed_b_o <= aohtr_pkg::FIX_B_RST;
    end else begin
      reg_rdata_o <= nxt_rdata;
      reg_ack_o <= in_range;
      offset_applied_o <= offset_ff;
      offset_hold_o <= hold_now;
      offset_settled_o <= (nxt_upd_cnt == aohtr_pkg::SETTLE_MAX);
      fixed_a_o <= fix_a_ff;
      fixed_b_o <= fix_b_ff;
    end
  end

  // ==========================================================================
  // Checks
  a_hold_freezes: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    hold_now |=> offset_ff == $past(offset_ff))
    else $error("offset changed while held");
  a_update_loads: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (offset_enable_i && update_tick_i && !hold_now) |=> offset_ff == $past(offset_calc_i))
    else $error("offset not loaded on update");
  a_settle_ten: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    upd_cnt_ff <= 4'd10)
    else $error("settle count past ten");
  a_ack_range: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    reg_addr_i > 8'h2e |=> !reg_ack_o)
    else $error("ack above last address");
  a_ro_stable: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    reg_addr_i == 8'h2a |=> reg_rdata_o == 8'h00)
    else $error("read-only byte changed");
  a_ro_nowrite: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    (reg_wr_i && reg_addr_i == 8'h2b) |=> $stable(hold_ctl_ff) && $stable(fix_a_ff))
    else $error("read-only write had effect");
  a_fix_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    sel_fix_b |=> ##1 fixed_b_o == $past(reg_wdata_i, 2))
    else $error("fixed byte not written");
  a_hold_out: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    sel_hold |=> ##1 offset_hold_o == $past(reg_wdata_i[4], 2))
    else $error("hold output wrong");
endmodule : aohtr_regs
`default_nettype wire

// ### sim/aohtr_host.sv
// Host model: serial engine side of the register port
`timescale 1ns/1ps
`default_nettype none
module aohtr_host (
  // Clock
  input wire logic clk_i,
  // Register port
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_o
);
  initial begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    wdata_o = 8'h00;
    rd_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wr_o <= 1'b1;
    wdata_o <= (a == 8'h2c) ? (d & 8'h10) : d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    // Stale data would hide a missed strobe
    wdata_o <= ~wdata_o;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
  endtask : rd
endmodule : aohtr_host
`default_nettype wire

// ### sim/aohtr_bench.sv
// Self-checking bench for the offset hold and test register bank
`timescale 1ns/1ps
`default_nettype none
module auto_offset_hold_test_regs_bench;
  // ==========================================================================
  // Wiring
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic en = 1'b0, tk = 1'b0, rd_d = 1'b0, rd, wr, ack, hold, stl;
  logic [7:0] calc = 8'h00, addr, wd, rdat, app, fa, fb, v;
  logic [8:0] exp_q[$];
  int n_mismatch = 0, checks_done = 0;
  always #2.5 ref_clk_i = ~ref_clk_i;
  aohtr_host host (.clk_i(ref_clk_i), .addr_o(addr), .wr_o(wr), .wdata_o(wd), .rd_o(rd));
  aohtr_regs uut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(addr), .reg_wr_i(wr),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_ack_o(ack), .offset_enable_i(en),
    .update_tick_i(tk), .offset_calc_i(calc), .offset_applied_o(app),
    .offset_hold_o(hold), .offset_settled_o(stl), .fixed_a_o(fa), .fixed_b_o(fb));
  task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic rx(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask : rx
  task automatic upd(input logic [7:0] c);
    @(posedge ref_clk_i);
    tk <= 1'b1;
    calc <= c;
    @(posedge ref_clk_i);
    tk <= 1'b0;
    calc <= ~c;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask : upd
  // ==========================================================================
  // Monitor: data of unacked reads is left unchecked
  always @(posedge ref_clk_i) rd_d <= rd;
  always @(negedge ref_clk_i) begin
    if (rd_d === 1'b1) begin
      exp_q[0][7:0] = exp_q[0][8] ? exp_q[0][7:0] : rdat;
      chk("read", exp_q.pop_front(), {ack, rdat});
    end
  end
  // Whole run is under a hundred cycles
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
  initial begin
    void'($urandom(32'hbd8b_2509));
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    for (int a = 8'h2a; a <= 8'h2f; a++) rx(8'(a), {a < 8'h2f, 8'h00});
    v = 8'($urandom());
    host.wr(8'h29, 8'h00);
    host.wr(8'h2d, v);
    host.wr(8'h2e, ~v);
    host.wr(8'h2a, v);
    host.wr(8'h2b, ~v);
    host.wr(8'h2c, 8'h00);
    rx(8'h2a, 9'h100);
    rx(8'h2b, 9'h100);
    rx(8'h2d, {1'b1, v});
    rx(8'h2e, {1'b1, ~v});
    chk("fixed", {1'b0, v}, {1'b0, fa});
    chk("fixed", {1'b0, ~v}, {1'b0, fb});
    // Calibration after power-up, updates left running first
    en <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      v = 8'($urandom());
      upd(v);
      chk("applied", {1'b0, v}, {1'b0, app});
    end
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("settled", 9'h001, {8'h00, stl});
    host.wr(8'h2c, 8'hff);
    upd(~v);
    chk("applied", {1'b1, v}, {hold, app});
    rx(8'h2c, 9'h110);
    repeat (3) @(posedge ref_clk_i);
    summarize();
  end
endmodule : auto_offset_hold_test_regs_bench
`default_nettype wire
